/* logic/tsrb_regs.svh */
// Purpose: offsets, field positions, reset values and timing counts of the tuner register bank
// Assumes: byte-wide registers at consecutive addresses
// Notes:   reset values follow the advisory defaults
`ifndef TSRB_REGS_SVH
`define TSRB_REGS_SVH

// register addresses
`define TSRB_ADDR_FB_DIV_HIGH   4'h0
`define TSRB_ADDR_FB_DIV_LOW    4'h1
`define TSRB_ADDR_REF_DIV       4'h2
`define TSRB_ADDR_OSC_CONFIG    4'h3
`define TSRB_ADDR_DET_PUMP_BAND 4'h4
`define TSRB_ADDR_INPUT_GAIN    4'h5
`define TSRB_ADDR_POWER_DOWN    4'h6
`define TSRB_ADDR_SERIES_CAP    4'h7
`define TSRB_ADDR_PARALLEL_CAP  4'h8
`define TSRB_ADDR_ROM_POINTER   4'h9
`define TSRB_ADDR_RESERVED_SLOT 4'ha
`define TSRB_ADDR_ROM_READBACK  4'hb
`define TSRB_ADDR_STATUS        4'hc
`define TSRB_NUM_RW             11

// field positions
`define TSRB_OSC_SEL_HI         7
`define TSRB_OSC_SEL_LO         6
`define TSRB_SUB_BAND_HI        5
`define TSRB_SUB_BAND_LO        3
`define TSRB_LOCK_EN_BIT        2
`define TSRB_POST_DIV_HI        1
`define TSRB_POST_DIV_LO        0
`define TSRB_FILTER_LOAD_BIT    7
`define TSRB_STAT_POR_BIT       7
`define TSRB_STAT_LOCK_HI       6
`define TSRB_STAT_LOCK_LO       4

// reset values (advisory defaults)
`define TSRB_FB_DIV_DEFAULT     15'd4688
`define TSRB_RST_FB_DIV_HIGH    8'h12
`define TSRB_RST_FB_DIV_LOW     8'h50
`define TSRB_RST_REF_DIV        8'h40
`define TSRB_RST_OSC_CONFIG     8'hbe
`define TSRB_RST_DET_PUMP_BAND  8'h00
`define TSRB_RST_INPUT_GAIN     8'h01
`define TSRB_RST_POWER_DOWN     8'h00
`define TSRB_RST_SERIES_CAP     8'h0f
`define TSRB_RST_PARALLEL_CAP   8'h09
`define TSRB_RST_ROM_POINTER    8'h00
`define TSRB_RST_RESERVED_SLOT  8'h00
`define TSRB_RST_ROM_READBACK   8'h00

// power-up settle time before the host programs the bank
`define TSRB_CLK_HZ             25000000
`define TSRB_SETTLE_US          100
// cycles per microsecond first, so the product stays inside a 32-bit integer
`define TSRB_SETTLE_CYCLES      (`TSRB_SETTLE_US * (`TSRB_CLK_HZ / 1000000))

`endif

/* logic/tsrb_pkg.sv */
// Purpose: shared types of the tuner register bank
// Assumes: nothing beyond the register header
// Notes:   types only
package tsrb_pkg;
    typedef logic [7:0] tsrb_byte_t;
    typedef logic [3:0] tsrb_addr_t;
    typedef enum logic [1:0] {
        TSRB_OSC_OFF,
        TSRB_OSC_ONE,
        TSRB_OSC_TWO,
        TSRB_OSC_THREE
    } tsrb_osc_t;
endpackage

/* logic/tsrb_bank.sv */
// Purpose: control register bank of the tuner synthesizer and front end
// Assumes: the serial slave engine delivers byte accesses on CLK_SYS as strobes
// Notes:   lock indicator comes from analog logic and is synchronised here
// Contract
// - eleven writable registers read back stored bytes
// - status and ROM readback registers are read-only
// - feedback divider is high[6:0] then low byte
// - feedback divider advisory default is 4688
// - reference divider is bits 6-0, 16..127
// - reference divider advisory default is 64
// - oscillator select code, zero powers all down
// - three bits pick one of eight sub-bands
// - bit two enables lock detect circuitry
// - post divider codes give 4,8,16,32
// - power flag set by reset, cleared by status read
// - lock field reports low, high or locked
// - filter-load rising edge loads ROM readback
`timescale 1ns/1ns
`include "tsrb_regs.svh"

module tsrb_bank
    import tsrb_pkg::*;
(
    input  wire logic        CLK_SYS,          // system clock, 25 MHz
    input  wire logic        RESETN,           // power-on reset, active low
    input  wire logic        REG_WR,           // write strobe from serial engine
    input  wire logic        REG_RD,           // read strobe from serial engine
    input  wire tsrb_addr_t  REG_ADDR,         // register address
    input  wire tsrb_byte_t  REG_WDATA,        // write data
    output      tsrb_byte_t  REG_RDATA,        // read data, registered
    output      logic        REG_RVALID,       // read data valid pulse
    input  wire logic [2:0]  LOCK_IND,         // lock indicator from analog side
    output      logic [3:0]  FILTER_ROM_POINTER, // ROM entry address
    input  wire tsrb_byte_t  ROM_DATA,         // ROM entry at the pointer
    output      logic [14:0] FEEDBACK_DIV,     // integer feedback divider
    output      logic [6:0]  REFERENCE_DIV,    // reference divider
    output      logic [2:0]  OSC_ENABLE,       // one-hot oscillator enable, zero is all off
    output      logic [2:0]  SUB_BAND,         // oscillator sub-band number
    output      logic        LOCK_DETECT_ENABLE, // lock detect circuitry enable
    output      logic [5:0]  POST_DIV_RATIO,   // post divider ratio 4..32
    output      tsrb_byte_t  DET_PUMP_BAND,    // detector, pump and band byte
    output      tsrb_byte_t  INPUT_GAIN,       // input and gain control byte
    output      tsrb_byte_t  POWER_DOWN,       // power-down control byte
    output      tsrb_byte_t  SERIES_CAP,       // series capacitor byte
    output      logic [5:0]  PARALLEL_CAP,     // parallel capacitor field
    output      tsrb_byte_t  FILTER_ROM_READBACK, // loaded ROM entry
    output      logic        SETTLE_DONE       // settle time since reset elapsed
);

    localparam int SETTLE_CYCLES = `TSRB_SETTLE_CYCLES;

    // advisory reset value of a writable register
    function automatic tsrb_byte_t default_of(input int idx);
        case (idx)
            0:       default_of = `TSRB_RST_FB_DIV_HIGH;
            1:       default_of = `TSRB_RST_FB_DIV_LOW;
            2:       default_of = `TSRB_RST_REF_DIV;
            3:       default_of = `TSRB_RST_OSC_CONFIG;
            4:       default_of = `TSRB_RST_DET_PUMP_BAND;
            5:       default_of = `TSRB_RST_INPUT_GAIN;
            6:       default_of = `TSRB_RST_POWER_DOWN;
            7:       default_of = `TSRB_RST_SERIES_CAP;
            8:       default_of = `TSRB_RST_PARALLEL_CAP;
            9:       default_of = `TSRB_RST_ROM_POINTER;
            default: default_of = `TSRB_RST_RESERVED_SLOT;
        endcase
    endfunction

    // post divider ratio from its two-bit code
    function automatic logic [5:0] post_ratio(input logic [1:0] code);
        post_ratio = 6'h04 << code;
    endfunction

    // one-hot oscillator enable from the select code
    function automatic logic [2:0] osc_onehot(input tsrb_osc_t sel);
        case (sel)
            TSRB_OSC_ONE:   osc_onehot = 3'h1;
            TSRB_OSC_TWO:   osc_onehot = 3'h2;
            TSRB_OSC_THREE: osc_onehot = 3'h4;
            default:        osc_onehot = 3'h0;
        endcase
    endfunction

    logic        rst_s1_r;
    logic        rst_n_r;
    tsrb_byte_t  cfg_r [0:`TSRB_NUM_RW-1];
    logic [2:0]  lock_s1_r;
    logic [2:0]  lock_s2_r;
    logic        por_r;
    logic        fld_prev_r;
    tsrb_byte_t  rdbk_r;
    logic [11:0] settle_cnt_r;
    logic        settle_done_r;
    logic        wr_rw;
    logic        fld_rise;
    tsrb_osc_t   osc_sel;
    tsrb_byte_t  rd_nxt;

    // reset synchroniser, asserts at once and releases after two edges
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            rst_s1_r <= 1'b0;
            rst_n_r  <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n_r  <= rst_s1_r;
        end
    end

    // lock indicator arrives from another domain
    always_ff @(posedge CLK_SYS or negedge rst_n_r) begin
        if (!rst_n_r) begin
            lock_s1_r <= 3'h0;
            lock_s2_r <= 3'h0;
        end else begin
            lock_s1_r <= LOCK_IND;
            lock_s2_r <= lock_s1_r;
        end
    end

    // only addresses below the read-only pair store
    assign wr_rw = REG_WR && (REG_ADDR < `TSRB_ADDR_ROM_READBACK);

    always_ff @(posedge CLK_SYS or negedge rst_n_r) begin
        if (!rst_n_r) begin
            for (int i = 0; i < `TSRB_NUM_RW; i++) begin
                cfg_r[i] <= default_of(i);
            end
        end else if (wr_rw) begin
            cfg_r[REG_ADDR] <= REG_WDATA;
        end
    end

    // rising edge of the filter-load bit
    assign fld_rise = cfg_r[`TSRB_ADDR_PARALLEL_CAP][`TSRB_FILTER_LOAD_BIT] && !fld_prev_r;

    always_ff @(posedge CLK_SYS or negedge rst_n_r) begin
        if (!rst_n_r) begin
            fld_prev_r <= 1'b0;
        end else begin
            fld_prev_r <= cfg_r[`TSRB_ADDR_PARALLEL_CAP][`TSRB_FILTER_LOAD_BIT];
        end
    end

    // readback only loads from the ROM
    always_ff @(posedge CLK_SYS or negedge rst_n_r) begin
        if (!rst_n_r) begin
            rdbk_r <= `TSRB_RST_ROM_READBACK;
        end else if (fld_rise) begin
            rdbk_r <= ROM_DATA;
        end
    end

    // power flag set by reset, cleared by status read
    always_ff @(posedge CLK_SYS or negedge rst_n_r) begin
        if (!rst_n_r) begin
            por_r <= 1'b1;
        end else if (REG_RD && REG_ADDR == `TSRB_ADDR_STATUS) begin
            por_r <= 1'b0;
        end
    end

    always_comb begin
        rd_nxt = 8'h00;
        if (REG_ADDR < `TSRB_ADDR_ROM_READBACK) begin
            rd_nxt = cfg_r[REG_ADDR];
        end else if (REG_ADDR == `TSRB_ADDR_ROM_READBACK) begin
            rd_nxt = rdbk_r;
        end else if (REG_ADDR == `TSRB_ADDR_STATUS) begin
            rd_nxt = {por_r, lock_s2_r, 4'h0};
        end
    end

    // registered read answer one cycle after the strobe
    always_ff @(posedge CLK_SYS or negedge rst_n_r) begin
        if (!rst_n_r) begin
            REG_RDATA  <= 8'h00;
            REG_RVALID <= 1'b0;
        end else begin
            REG_RVALID <= REG_RD;
            if (REG_RD) begin
                REG_RDATA <= rd_nxt;
            end
        end
    end

    // settle counter tells the host when programming may start
    always_ff @(posedge CLK_SYS or negedge rst_n_r) begin
        if (!rst_n_r) begin
            settle_cnt_r  <= 12'h000;
            settle_done_r <= 1'b0;
        end else if (!settle_done_r) begin
            settle_cnt_r  <= settle_cnt_r + 12'h001;
            settle_done_r <= (settle_cnt_r == 12'(SETTLE_CYCLES - 1));
        end
    end

    assign FEEDBACK_DIV  = {cfg_r[`TSRB_ADDR_FB_DIV_HIGH][6:0], cfg_r[`TSRB_ADDR_FB_DIV_LOW]};
    assign REFERENCE_DIV = cfg_r[`TSRB_ADDR_REF_DIV][6:0];

    assign osc_sel    = tsrb_osc_t'(cfg_r[`TSRB_ADDR_OSC_CONFIG][`TSRB_OSC_SEL_HI:`TSRB_OSC_SEL_LO]);
    assign OSC_ENABLE = osc_onehot(osc_sel);
    // sub-band number straight from the code
    assign SUB_BAND   = cfg_r[`TSRB_ADDR_OSC_CONFIG][`TSRB_SUB_BAND_HI:`TSRB_SUB_BAND_LO];
    assign LOCK_DETECT_ENABLE = cfg_r[`TSRB_ADDR_OSC_CONFIG][`TSRB_LOCK_EN_BIT];
    assign POST_DIV_RATIO = post_ratio(cfg_r[`TSRB_ADDR_OSC_CONFIG][`TSRB_POST_DIV_HI:`TSRB_POST_DIV_LO]);

    // remaining control bytes go straight to the front end, parallel cap and ROM pointer as their low fields
    assign DET_PUMP_BAND       = cfg_r[`TSRB_ADDR_DET_PUMP_BAND];
    assign INPUT_GAIN          = cfg_r[`TSRB_ADDR_INPUT_GAIN];
    assign POWER_DOWN          = cfg_r[`TSRB_ADDR_POWER_DOWN];
    assign SERIES_CAP          = cfg_r[`TSRB_ADDR_SERIES_CAP];
    assign PARALLEL_CAP        = cfg_r[`TSRB_ADDR_PARALLEL_CAP][5:0];
    assign FILTER_ROM_POINTER  = cfg_r[`TSRB_ADDR_ROM_POINTER][3:0];
    assign FILTER_ROM_READBACK = rdbk_r;
    assign SETTLE_DONE         = settle_done_r;

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!rst_n_r);

    // write then read of the low divider byte returns it
    chk_rw_read_back: assert property (
        (REG_WR && REG_ADDR == `TSRB_ADDR_FB_DIV_LOW) ##1 (REG_RD && REG_ADDR == `TSRB_ADDR_FB_DIV_LOW && !REG_WR)
        |=> REG_RDATA == $past(REG_WDATA, 2))
        else $error("stored byte not read back");

    // read-only registers ignore writes
    chk_ro_write_ignored: assert property (
        (REG_WR && REG_ADDR >= `TSRB_ADDR_ROM_READBACK && !fld_rise) |=> ($stable(rdbk_r) && $stable(FEEDBACK_DIV)))
        else $error("write to read-only register changed state");

    // status read shows and then clears the power flag
    chk_status_por_clear: assert property (
        (REG_RD && REG_ADDR == `TSRB_ADDR_STATUS) |=> (!por_r && REG_RVALID && REG_RDATA[7] == $past(por_r)))
        else $error("power flag not reported or not cleared");

    // power flag is set out of reset
    chk_por_after_reset: assert property (
        $rose(rst_n_r) |-> por_r)
        else $error("power flag clear after reset");

    // lock field in status follows the synchronised indicator
    chk_lock_status: assert property (
        (REG_RD && REG_ADDR == `TSRB_ADDR_STATUS) |=> REG_RDATA[6:4] == $past(lock_s2_r) && REG_RDATA[3:0] == 4'h0)
        else $error("lock field wrong in status");

    // divider high byte lands in bits 14 to 8
    chk_feedback_high: assert property (
        (REG_WR && REG_ADDR == `TSRB_ADDR_FB_DIV_HIGH) |=> FEEDBACK_DIV[14:8] == $past(REG_WDATA[6:0]))
        else $error("feedback divider high bits wrong");

    // reference divider follows its write
    chk_reference_div: assert property (
        (REG_WR && REG_ADDR == `TSRB_ADDR_REF_DIV) |=> REFERENCE_DIV == $past(REG_WDATA[6:0]))
        else $error("reference divider wrong");

    // advisory defaults right after reset
    chk_reset_defaults: assert property (
        $rose(rst_n_r) |-> (FEEDBACK_DIV == `TSRB_FB_DIV_DEFAULT && REFERENCE_DIV == 7'h40))
        else $error("divider defaults wrong after reset");

    // oscillator enable one-hot, all off only for code zero
    chk_osc_select: assert property (
        (REG_WR && REG_ADDR == `TSRB_ADDR_OSC_CONFIG) |=>
        ($onehot0(OSC_ENABLE) && ((OSC_ENABLE == 3'h0) == ($past(REG_WDATA[7:6]) == 2'b00))
         && SUB_BAND == $past(REG_WDATA[5:3]) && LOCK_DETECT_ENABLE == $past(REG_WDATA[2])))
        else $error("oscillator fields wrong");

    // post divider code three gives ratio 32
    chk_post_div: assert property (
        (REG_WR && REG_ADDR == `TSRB_ADDR_OSC_CONFIG && REG_WDATA[1:0] == 2'b11) |=> POST_DIV_RATIO == 6'h20)
        else $error("post divider ratio wrong");

    // filter-load rising edge captures the ROM entry two cycles on
    chk_rom_load: assert property (
        (REG_WR && REG_ADDR == `TSRB_ADDR_PARALLEL_CAP && REG_WDATA[7] && !cfg_r[`TSRB_ADDR_PARALLEL_CAP][7])
        |-> ##2 rdbk_r == $past(ROM_DATA))
        else $error("ROM readback not loaded on filter load");

    // read valid answers every read strobe one cycle later and nothing else
    chk_rvalid_pulse: assert property (
        1'b1 |=> REG_RVALID == $past(REG_RD))
        else $error("read valid does not follow read strobe");

    // ROM readback register is what a read of its address returns
    chk_readback_read: assert property (
        (REG_RD && REG_ADDR == `TSRB_ADDR_ROM_READBACK) |=> REG_RDATA == $past(rdbk_r))
        else $error("ROM readback read wrong");

    // readback only moves after a rising filter-load bit
    chk_readback_holds: assert property (
        !$rose(cfg_r[`TSRB_ADDR_PARALLEL_CAP][`TSRB_FILTER_LOAD_BIT]) |=> $stable(rdbk_r))
        else $error("ROM readback changed without filter load");

    // divider low byte lands in bits 7 to 0
    chk_feedback_low: assert property (
        (REG_WR && REG_ADDR == `TSRB_ADDR_FB_DIV_LOW) |=> FEEDBACK_DIV[7:0] == $past(REG_WDATA))
        else $error("feedback divider low bits wrong");

    // divider holds unless one of its two bytes is written
    chk_divider_holds: assert property (
        !(REG_WR && REG_ADDR <= `TSRB_ADDR_FB_DIV_LOW) |=> $stable(FEEDBACK_DIV))
        else $error("feedback divider changed without a write");

    // oscillator fields hold unless their register is written
    chk_osc_holds: assert property (
        !(REG_WR && REG_ADDR == `TSRB_ADDR_OSC_CONFIG) |=>
        ($stable(LOCK_DETECT_ENABLE) && $stable(SUB_BAND) && $stable(OSC_ENABLE)))
        else $error("oscillator fields changed without a write");

    // oscillator enable matches the stored select code
    chk_osc_map: assert property (
        OSC_ENABLE == {cfg_r[`TSRB_ADDR_OSC_CONFIG][7:6] == 2'b11, cfg_r[`TSRB_ADDR_OSC_CONFIG][7:6] == 2'b10,
                       cfg_r[`TSRB_ADDR_OSC_CONFIG][7:6] == 2'b01})
        else $error("oscillator enable does not match code");

    // post divider ratio matches the stored code
    chk_post_div_map: assert property (
        POST_DIV_RATIO == ((cfg_r[`TSRB_ADDR_OSC_CONFIG][1:0] == 2'b00) ? 6'h04 :
                           (cfg_r[`TSRB_ADDR_OSC_CONFIG][1:0] == 2'b01) ? 6'h08 :
                           (cfg_r[`TSRB_ADDR_OSC_CONFIG][1:0] == 2'b10) ? 6'h10 : 6'h20))
        else $error("post divider ratio does not match code");

    // power flag only moves on a status read
    chk_flag_kept: assert property (
        !(REG_RD && REG_ADDR == `TSRB_ADDR_STATUS) |=> $stable(por_r))
        else $error("power flag changed without status read");

    // settle flag stays up once raised
    chk_settle_held: assert property (
        settle_done_r |=> settle_done_r)
        else $error("settle flag dropped");

    // settle flag rises after the full settle count
    chk_settle_count: assert property (
        $rose(settle_done_r) |-> settle_cnt_r == 12'(SETTLE_CYCLES))
        else $error("settle flag rose at wrong count");

    // synchronised lock indicator lags the pin by two edges
    chk_lock_sync: assert property (
        $past(rst_n_r, 2) |-> lock_s2_r == $past(LOCK_IND, 2))
        else $error("lock indicator synchroniser delay wrong");

endmodule

/* test/tsrb_rom_model.sv */
// Purpose: stand-in for the filter coefficient ROM behind the register bank
// Assumes: the ROM answers combinationally in the CLK_SYS domain
// Notes:   contents are a fixed pattern so that every entry differs
`timescale 1ns/1ns
module tsrb_rom_model
    import tsrb_pkg::*;
(
    input  wire logic [3:0] FILTER_ROM_POINTER, // entry address
    output      tsrb_byte_t ROM_DATA            // entry contents
);
    assign ROM_DATA = {~FILTER_ROM_POINTER, FILTER_ROM_POINTER} ^ 8'h5a;
endmodule

/* test/tsrb_tb.sv */
// Purpose: self-checking bench for the tuner register bank
// Assumes: byte strobes are driven at the falling edge, one access at a time except in the back-to-back test
// Notes:   the host side waits for the settle flag before programming the bank
`timescale 1ns/1ns
`include "tsrb_regs.svh"
module testbench;
    import tsrb_pkg::*;
    logic        clk_sys, resetn, reg_wr, reg_rd, reg_rvalid, lock_en, settle_done;
    tsrb_addr_t  reg_addr;
    tsrb_byte_t  reg_wdata, reg_rdata, rom_data, det, gain, pwr, ser, rdbk;
    logic [2:0]  lock_ind, osc_en, sub_band;
    logic [3:0]  rom_ptr;
    logic [14:0] fb_div;
    logic [6:0]  ref_div;
    logic [5:0]  post_div, par_cap;
    int          fails = 0;
    int          compares = 0;
    tsrb_byte_t  rst_tab [11] = '{`TSRB_RST_FB_DIV_HIGH, `TSRB_RST_FB_DIV_LOW, `TSRB_RST_REF_DIV,
        `TSRB_RST_OSC_CONFIG, `TSRB_RST_DET_PUMP_BAND, `TSRB_RST_INPUT_GAIN, `TSRB_RST_POWER_DOWN,
        `TSRB_RST_SERIES_CAP, `TSRB_RST_PARALLEL_CAP, `TSRB_RST_ROM_POINTER, `TSRB_RST_RESERVED_SLOT};
    // fixed-zero bits kept clear, dividers at their range edges
    tsrb_byte_t  wr_tab [11] = '{8'h7f, 8'hff, 8'h10, 8'h5d, 8'h3c, 8'h0f, 8'hf8, 8'ha5, 8'h2a, 8'h0c, 8'h96};

    tsrb_bank DUT (.CLK_SYS(clk_sys), .RESETN(resetn), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_ADDR(reg_addr),
        .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .REG_RVALID(reg_rvalid), .LOCK_IND(lock_ind),
        .FILTER_ROM_POINTER(rom_ptr), .ROM_DATA(rom_data), .FEEDBACK_DIV(fb_div), .REFERENCE_DIV(ref_div),
        .OSC_ENABLE(osc_en), .SUB_BAND(sub_band), .LOCK_DETECT_ENABLE(lock_en), .POST_DIV_RATIO(post_div),
        .DET_PUMP_BAND(det), .INPUT_GAIN(gain), .POWER_DOWN(pwr), .SERIES_CAP(ser), .PARALLEL_CAP(par_cap),
        .FILTER_ROM_READBACK(rdbk), .SETTLE_DONE(settle_done));
    tsrb_rom_model ROM (.FILTER_ROM_POINTER(rom_ptr), .ROM_DATA(rom_data));

    // clock, 40 ns period
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    function automatic tsrb_byte_t rom_exp(input logic [3:0] p);
        return {~p, p} ^ 8'h5a;
    endfunction

    task automatic cmp(input logic [14:0] act, input logic [14:0] exp, input string what);
        compares++;
        if (act !== exp) begin
            fails++;
            $display("FAIL %0t %s got %h want %h", $time, what, act, exp);
        end
    endtask

    // one write strobe, then an idle cycle so strobes never merge
    task automatic wr(input tsrb_addr_t a, input tsrb_byte_t d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk_sys);
        reg_wr = 1'b0;
        @(negedge clk_sys);
    endtask

    // one read strobe; valid stands for exactly one cycle
    task automatic rdc(input tsrb_addr_t a, input tsrb_byte_t e, input string what);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk_sys);
        reg_rd = 1'b0;
        cmp(reg_rvalid, 1'b1, "valid high");
        cmp(reg_rdata, e, what);
        @(negedge clk_sys);
        cmp(reg_rvalid, 1'b0, "valid low");
    endtask

    task automatic test_defaults();
        int n;
        n = 0;
        cmp(settle_done, 1'b0, "settle early");
        for (int i = 0; i < 11; i++) rdc(i[3:0], rst_tab[i], "default");
        cmp(fb_div, 15'h1250, "fb default");
        cmp(ref_div, 7'h40, "ref default");
        cmp({osc_en, sub_band, lock_en, post_div}, {3'h2, 3'h7, 1'b1, 6'h10}, "osc default");
        rdc(`TSRB_ADDR_STATUS, 8'hf0, "status after reset");
        rdc(`TSRB_ADDR_STATUS, 8'h70, "status after read");
        // wait out the settle time before programming
        while (settle_done !== 1'b1 && n < 3000) begin
            @(negedge clk_sys);
            n++;
        end
        cmp(settle_done, 1'b1, "settle done");
        cmp(n >= 2400, 1'b1, "settle length");
    endtask

    task automatic test_lock();
        logic [2:0] v [3] = '{3'b000, 3'b111, 3'b011};
        for (int i = 0; i < 3; i++) begin
            lock_ind = v[i];
            repeat (3) @(negedge clk_sys);
            rdc(`TSRB_ADDR_STATUS, {1'b0, v[i], 4'h0}, "lock field");
        end
    endtask

    task automatic test_rw_all();
        for (int i = 0; i < 11; i++) wr(i[3:0], wr_tab[i]);
        for (int i = 0; i < 11; i++) rdc(i[3:0], wr_tab[i], "readback");
        cmp(fb_div, 15'h7fff, "fb max");
        cmp(ref_div, 7'h10, "ref min");
        cmp(det, 8'h3c, "detector byte");
        cmp(gain, 8'h0f, "gain byte");
        cmp(pwr, 8'hf8, "power byte");
        cmp(ser, 8'ha5, "series byte");
        cmp({par_cap, rom_ptr}, {6'h2a, 4'hc}, "cap and pointer");
        wr(`TSRB_ADDR_FB_DIV_LOW, 8'h00);
        wr(`TSRB_ADDR_FB_DIV_HIGH, 8'h01);
        cmp(fb_div, 15'h0100, "fb min");
    endtask

    task automatic test_osc();
        logic [2:0] oe;
        for (int i = 0; i < 8; i++) begin
            wr(`TSRB_ADDR_OSC_CONFIG, {i[1:0], i[2:0], i[0], ~i[1:0]});
            oe = (i[1:0] == 2'b00) ? 3'h0 : 3'h1 << (i[1:0] - 2'h1);
            cmp(osc_en, oe, "osc select");
            cmp(sub_band, i[2:0], "sub band");
            cmp(lock_en, i[0], "lock enable");
            cmp(post_div, 6'h04 << ~i[1:0], "post div");
        end
    endtask

    task automatic test_filter_load();
        wr(`TSRB_ADDR_ROM_POINTER, 8'h05);
        wr(`TSRB_ADDR_PARALLEL_CAP, 8'h89);
        @(negedge clk_sys);
        rdc(`TSRB_ADDR_ROM_READBACK, rom_exp(4'h5), "rom load");
        wr(`TSRB_ADDR_ROM_POINTER, 8'h03);
        wr(`TSRB_ADDR_PARALLEL_CAP, 8'h89);
        @(negedge clk_sys);
        cmp(rdbk, rom_exp(4'h5), "one over one");
        wr(`TSRB_ADDR_PARALLEL_CAP, 8'h09);
        wr(`TSRB_ADDR_PARALLEL_CAP, 8'h89);
        @(negedge clk_sys);
        cmp(rdbk, rom_exp(4'h3), "reload");
    endtask

    task automatic test_read_only();
        wr(`TSRB_ADDR_ROM_READBACK, 8'hff);
        wr(`TSRB_ADDR_STATUS, 8'hff);
        wr(4'hd, 8'hff);
        rdc(`TSRB_ADDR_ROM_READBACK, rom_exp(4'h3), "readback kept");
        rdc(`TSRB_ADDR_STATUS, {1'b0, lock_ind, 4'h0}, "status kept");
        cmp(fb_div, 15'h0100, "state kept");
        rdc(4'hd, 8'h00, "unmapped read");
    endtask

    // write then read with no gap, then both strobes in one cycle
    task automatic test_back_to_back();
        reg_addr = `TSRB_ADDR_FB_DIV_LOW;
        reg_wdata = 8'ha7;
        reg_wr = 1'b1;
        @(negedge clk_sys);
        reg_wr = 1'b0;
        reg_rd = 1'b1;
        @(negedge clk_sys);
        cmp(reg_rvalid, 1'b1, "back to back valid");
        cmp(reg_rdata, 8'ha7, "back to back read");
        reg_wdata = 8'h5b;
        reg_wr = 1'b1;
        @(negedge clk_sys);
        reg_wr = 1'b0;
        cmp(reg_rdata, 8'ha7, "same cycle read old");
        @(negedge clk_sys);
        reg_rd = 1'b0;
        cmp(reg_rdata, 8'h5b, "read after same cycle");
        cmp(fb_div, 15'h015b, "fb low byte alone");
        @(negedge clk_sys);
        cmp(reg_rvalid, 1'b0, "valid drops");
    endtask

    task automatic wrap_up();
        if (fails == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        resetn = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        lock_ind = 3'b111;
        repeat (6) @(negedge clk_sys);
        resetn = 1'b1;
        repeat (3) @(negedge clk_sys);
        test_defaults();
        test_lock();
        test_rw_all();
        test_osc();
        test_filter_load();
        test_read_only();
        test_back_to_back();
        wrap_up();
    end

    // watchdog, well beyond the settle time and the scenarios
    initial begin
        #200000;
        fails++;
        wrap_up();
    end
endmodule
